//--- common/dpr_pkg.sv
/*
 * Shared constants and types for the two-port memory block and its user end.
 * Assumes both ends run on one system clock; port clocks are enable pulses.
 */
package dpr_pkg;

	// Geometry
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 9;
	localparam int PAYLOAD_W   = 8;
	localparam int PARITY_BIT  = 8;
	localparam int DEPTH       = 256;

	// Reset values
	localparam logic [8:0] WORD_RST = 9'h000;
	localparam logic [7:0] ADDR_RST = 8'h00;

	// Port clock dividers, in system clock cycles per port clock
	localparam int WR_DIV_DEF  = 4;
	localparam int RD_DIV_DEF  = 4;

	// Read output timing
	typedef enum logic {
		DPR_TRANSPARENT,
		DPR_PIPELINED
	} dpr_rd_mode_type;

endpackage : dpr_pkg

//--- common/dpr_if.sv
/*
 * Port bundle between the memory block and the user logic beside it.
 * Assumes write_clock and read_clock are one-cycle enables of the system clock.
 */
`timescale 1ns/1ps
interface dpr_if;
	logic                       write_clock;
	logic [dpr_pkg::ADDR_W-1:0] write_address;
	logic                       write_select_n;
	logic                       write_strobe_n;
	logic [dpr_pkg::DATA_W-1:0] write_data_in;
	logic                       parity_generate;
	logic                       parity_odd_select;
	logic                       read_clock;
	logic [dpr_pkg::ADDR_W-1:0] read_address;
	logic                       read_select_n;
	logic                       read_strobe_n;
	dpr_pkg::dpr_rd_mode_type   read_mode;
	logic [dpr_pkg::DATA_W-1:0] read_data_out;
	logic                       read_parity_error;
	logic                       write_parity_error;

	modport mem (
		input  write_clock, write_address, write_select_n, write_strobe_n, write_data_in,
		input  parity_generate, parity_odd_select,
		input  read_clock, read_address, read_select_n, read_strobe_n, read_mode,
		output read_data_out, read_parity_error, write_parity_error
	);

	modport user (
		output write_clock, write_address, write_select_n, write_strobe_n, write_data_in,
		output parity_generate, parity_odd_select,
		output read_clock, read_address, read_select_n, read_strobe_n, read_mode,
		input  read_data_out, read_parity_error, write_parity_error
	);
endinterface : dpr_if

//--- core/dpr_mem_block.sv
/*
 * Two-port 256 x 9 memory block in plain memory mode, with optional parity,
 * transparent or pipelined read output and same-address write forwarding.
 * Assumes the user end drives the port clocks as enables of CLK_I and keeps
 * selects and strobes stable across each port clock pulse.
 * Port clock edges coincide or lie a full cycle apart, so the unknown-data
 * window around a same-word write and read never opens and is not modelled.
 */
`timescale 1ns/1ps

// Summary of operation
// - Same-address collision passes input to output
// - Transparent read valid within launching cycle
// - Pipelined read changes after second edge
// - User gives separate 8-bit read/write addresses
// - Write and read sides use own clocks
// - Read block select is active low
// - Read strobe is active low
// - Write needs select and strobe both low
// - Words are nine bits, bit eight parity
// - Read parity error flags bad read word
// - Write parity error flags bad write word
// - Parity select high odd, low even
// - Write at or before read returns new
// - Negative setup forwards on common clock
// - Write after hold window returns old
// - Write inside window gives unknown data (not modelled; port clock edges never fall inside it)
// - Collision rule same in both modes
module dpr_mem_block #(
	parameter int DEPTH  = dpr_pkg::DEPTH,
	parameter int ADDR_W = dpr_pkg::ADDR_W,
	parameter int DATA_W = dpr_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic CLK_I,
	input  wire logic ARST_N_I,
	// Memory ports
	dpr_if.mem        PORT
);

	// Parity bit that makes the payload match the chosen sense
	function automatic logic par_bit(input logic [dpr_pkg::PAYLOAD_W-1:0] payload,
			input logic odd);
		par_bit = (^payload) ^ odd;
	endfunction : par_bit

	// True when a nine-bit word breaks the chosen sense
	function automatic logic par_fail(input logic [dpr_pkg::DATA_W-1:0] word,
			input logic odd);
		par_fail = (^word) != odd;
	endfunction : par_fail

	// A port acts on its own clock pulse with select and strobe both low
	function automatic logic port_take(input logic pulse, input logic sel_n,
			input logic strobe_n);
		port_take = pulse & ~sel_n & ~strobe_n;
	endfunction : port_take

	// Storage
	logic [DATA_W-1:0] mem_r   [DEPTH];
	logic [DATA_W-1:0] mem_nxt [DEPTH];

	// Output state
	logic [DATA_W-1:0] stage_r;
	logic [DATA_W-1:0] stage_nxt;
	logic              stage_err_r;
	logic              stage_err_nxt;
	logic [DATA_W-1:0] dout_r;
	logic [DATA_W-1:0] dout_nxt;
	logic              rpe_r;
	logic              rpe_nxt;
	logic              wpe_r;
	logic              wpe_nxt;

	// Port decode
	logic              wr_en;
	logic              rd_en;
	logic              collide;
	logic [DATA_W-1:0] wr_word;
	logic [DATA_W-1:0] rd_word;
	logic              rd_err;

	// Write side acts only on its own clock pulse, read side on its own
	assign wr_en = port_take(PORT.write_clock, PORT.write_select_n,
		PORT.write_strobe_n);
	assign rd_en = port_take(PORT.read_clock, PORT.read_select_n,
		PORT.read_strobe_n);

	// Stored word, with bit eight generated when asked
	always_comb begin
		wr_word = PORT.write_data_in;
		if (PORT.parity_generate) begin
			wr_word[dpr_pkg::PARITY_BIT] = par_bit(
				PORT.write_data_in[dpr_pkg::PAYLOAD_W-1:0],
				PORT.parity_odd_select);
		end
	end

	// Write edge at or before the read edge on the same word forwards new data.
	// Both port clocks are enables of one clock, so the edges either coincide or
	// are a full system cycle apart; the unknown window cannot arise here.
	assign collide = wr_en & rd_en & (PORT.write_address == PORT.read_address);

	// Collided reads take the input bus, others the stored word
	always_comb begin
		if (collide) begin
			rd_word = wr_word;
		end else begin
			rd_word = mem_r[PORT.read_address];
		end
	end

	// Checked on the word that leaves, forwarded or stored
	assign rd_err = par_fail(rd_word, PORT.parity_odd_select);

	// Memory update
	always_comb begin
		mem_nxt = mem_r;
		if (wr_en) begin
			mem_nxt[PORT.write_address] = wr_word;
		end
	end

	// Cleared at reset so a read before any write gives a known word
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= dpr_pkg::WORD_RST;
			end
		end else begin
			mem_r <= mem_nxt;
		end
	end

	// Write parity check holds its result until the next write
	always_comb begin
		wpe_nxt = wpe_r;
		if (wr_en) begin
			if (PORT.parity_generate) begin
				// A generated bit is right by construction
				wpe_nxt = 1'b0;
			end else begin
				wpe_nxt = par_fail(PORT.write_data_in, PORT.parity_odd_select);
			end
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			wpe_r <= 1'b0;
		end else begin
			wpe_r <= wpe_nxt;
		end
	end

	// Read output path: stage captures at launch, output follows by mode
	always_comb begin
		stage_nxt     = stage_r;
		stage_err_nxt = stage_err_r;
		dout_nxt      = dout_r;
		rpe_nxt       = rpe_r;
		// Stage holds the launched word until the next read port clock with select and strobe both low
		if (rd_en) begin
			stage_nxt     = rd_word;
			stage_err_nxt = rd_err;
		end
		// Pipelined output reloads from the stage on every read port clock
		case (PORT.read_mode)
			dpr_pkg::DPR_TRANSPARENT: begin
				if (rd_en) begin
					dout_nxt = rd_word;
					rpe_nxt  = rd_err;
				end
			end
			dpr_pkg::DPR_PIPELINED: begin
				if (PORT.read_clock) begin
					dout_nxt = stage_r;
					rpe_nxt  = stage_err_r;
				end
			end
			default: begin
				dout_nxt = dout_r;
				rpe_nxt  = rpe_r;
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			stage_r     <= dpr_pkg::WORD_RST;
			stage_err_r <= 1'b0;
			dout_r      <= dpr_pkg::WORD_RST;
			rpe_r       <= 1'b0;
		end else begin
			stage_r     <= stage_nxt;
			stage_err_r <= stage_err_nxt;
			dout_r      <= dout_nxt;
			rpe_r       <= rpe_nxt;
		end
	end

	// Outputs
	assign PORT.read_data_out      = dout_r;
	assign PORT.read_parity_error  = rpe_r;
	assign PORT.write_parity_error = wpe_r;

endmodule : dpr_mem_block

//--- core/dpr_user_port.sv
/*
 * User-logic end of the memory block: makes both port clocks by division,
 * holds each request until its port clock takes it, and returns read data.
 * Assumes user requests come from logic on CLK_I.
 */
`timescale 1ns/1ps
module dpr_user_port #(
	parameter int WR_DIV = dpr_pkg::WR_DIV_DEF,
	parameter int RD_DIV = dpr_pkg::RD_DIV_DEF
) (
	// Clock and reset
	input  wire logic                       CLK_I,
	input  wire logic                       ARST_N_I,
	// Configuration
	input  wire logic                       PAR_GEN_I,
	input  wire logic                       PAR_ODD_I,
	input  wire logic                       PIPELINED_I,
	// Write request
	input  wire logic                       WR_REQ_I,
	input  wire logic [dpr_pkg::ADDR_W-1:0] WR_ADDR_I,
	input  wire logic [dpr_pkg::DATA_W-1:0] WR_DATA_I,
	output wire logic                       WR_READY_O,
	output wire logic                       WR_PERR_O,
	// Read request
	input  wire logic                       RD_REQ_I,
	input  wire logic [dpr_pkg::ADDR_W-1:0] RD_ADDR_I,
	output wire logic                       RD_READY_O,
	output wire logic                       RD_VALID_O,
	output wire logic [dpr_pkg::DATA_W-1:0] RD_DATA_O,
	output wire logic                       RD_PERR_O,
	// Memory ports
	dpr_if.user                             PORT
);

	logic [7:0]                 wdiv_r, wdiv_nxt, rdiv_r, rdiv_nxt;
	logic                       wtick, rtick;
	logic                       wpend_r, wpend_nxt, rpend_r, rpend_nxt;
	logic [dpr_pkg::ADDR_W-1:0] write_address_r, write_address_nxt, read_address_r, read_address_nxt;
	logic [dpr_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
	logic                       pipe_r, pipe_nxt, valid_r, valid_nxt;

	assign wtick = (wdiv_r == 8'(WR_DIV - 1));
	assign rtick = (rdiv_r == 8'(RD_DIV - 1));

	// Dividers and request holding
	always_comb begin
		wdiv_nxt  = wtick ? 8'h00 : wdiv_r + 8'h01;
		rdiv_nxt  = rtick ? 8'h00 : rdiv_r + 8'h01;
		wpend_nxt = wpend_r;
		write_address_nxt = write_address_r;
		wdata_nxt = wdata_r;
		rpend_nxt = rpend_r;
		read_address_nxt = read_address_r;
		pipe_nxt  = pipe_r & ~rtick;
		valid_nxt = 1'b0;
		if (wpend_r && wtick) begin
			wpend_nxt = 1'b0;
		end else if (!wpend_r && WR_REQ_I) begin
			wpend_nxt = 1'b1;
			write_address_nxt = WR_ADDR_I;
			wdata_nxt = WR_DATA_I;
		end
		if (pipe_r && rtick) begin
			valid_nxt = 1'b1;
		end
		if (rpend_r && rtick) begin
			rpend_nxt = 1'b0;
			if (PIPELINED_I) begin
				pipe_nxt = 1'b1;
			end else begin
				valid_nxt = 1'b1;
			end
		end else if (!rpend_r && RD_REQ_I) begin
			rpend_nxt = 1'b1;
			read_address_nxt = RD_ADDR_I;
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			wdiv_r  <= 8'h00;
			rdiv_r  <= 8'h00;
			wpend_r <= 1'b0;
			write_address_r <= dpr_pkg::ADDR_RST;
			wdata_r <= dpr_pkg::WORD_RST;
			rpend_r <= 1'b0;
			read_address_r <= dpr_pkg::ADDR_RST;
			pipe_r  <= 1'b0;
			valid_r <= 1'b0;
		end else begin
			wdiv_r  <= wdiv_nxt;
			rdiv_r  <= rdiv_nxt;
			wpend_r <= wpend_nxt;
			write_address_r <= write_address_nxt;
			wdata_r <= wdata_nxt;
			rpend_r <= rpend_nxt;
			read_address_r <= read_address_nxt;
			pipe_r  <= pipe_nxt;
			valid_r <= valid_nxt;
		end
	end

	// Port drive
	assign PORT.write_clock       = wtick;
	assign PORT.write_address     = write_address_r;
	assign PORT.write_select_n    = ~wpend_r;
	assign PORT.write_strobe_n    = ~wpend_r;
	assign PORT.write_data_in     = wdata_r;
	assign PORT.parity_generate   = PAR_GEN_I;
	assign PORT.parity_odd_select = PAR_ODD_I;
	assign PORT.read_clock        = rtick;
	assign PORT.read_address      = read_address_r;
	assign PORT.read_select_n     = ~rpend_r;
	assign PORT.read_strobe_n     = ~rpend_r;
	assign PORT.read_mode         = PIPELINED_I ? dpr_pkg::DPR_PIPELINED : dpr_pkg::DPR_TRANSPARENT;

	// User outputs
	assign WR_READY_O = ~wpend_r;
	assign RD_READY_O = ~rpend_r & ~pipe_r;
	assign RD_VALID_O = valid_r;
	assign RD_DATA_O  = PORT.read_data_out;
	assign RD_PERR_O  = PORT.read_parity_error;
	assign WR_PERR_O  = PORT.write_parity_error;

endmodule : dpr_user_port

//--- bench/dpr_monitor.sv
/*
 * Checker on the bundle between the memory block and its user end.
 * Assumes both port clocks are in-step enables of CLK_I.
 */
`timescale 1ns/1ps
module dpr_monitor #(
	parameter int WR_DIV = 4,
	parameter int RD_DIV = 4
) (
	// Clock and reset
	input logic                       CLK_I,
	input logic                       ARST_N_I,
	// Write side
	input logic                       write_clock,
	input logic [dpr_pkg::ADDR_W-1:0] write_address,
	input logic                       write_select_n,
	input logic                       write_strobe_n,
	input logic [dpr_pkg::DATA_W-1:0] write_data_in,
	input logic                       parity_generate,
	input logic                       parity_odd_select,
	input logic                       write_parity_error,
	// Read side
	input logic                       read_clock,
	input logic [dpr_pkg::ADDR_W-1:0] read_address,
	input logic                       read_select_n,
	input logic                       read_strobe_n,
	input dpr_pkg::dpr_rd_mode_type   read_mode,
	input logic [dpr_pkg::DATA_W-1:0] read_data_out,
	input logic                       read_parity_error
);
	logic       wr_take, rd_take, coll, werr_exp, rd_tr;
	logic [8:0] fwd_w;

	always_comb begin
		wr_take  = write_clock && !write_select_n && !write_strobe_n;
		rd_take  = read_clock && !read_select_n && !read_strobe_n;
		coll     = wr_take && rd_take && (write_address == read_address);
		rd_tr    = (read_mode == dpr_pkg::DPR_TRANSPARENT);
		werr_exp = !parity_generate && ((^write_data_in) ^ parity_odd_select);
		fwd_w    = write_data_in;
		if (parity_generate)
			fwd_w[8] = (^write_data_in[7:0]) ^ parity_odd_select;
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);

	sequence s_pipe_out;
		read_clock ##1 (read_data_out == $past(fwd_w, RD_DIV + 1));
	endsequence

	chk_wpar_value: assert property (wr_take |=> write_parity_error == $past(werr_exp))
		else $error("write parity flag wrong");
	chk_wpar_hold: assert property (!wr_take |=> $stable(write_parity_error))
		else $error("write parity flag moved");
	chk_fwd_trans: assert property (coll && rd_tr |=> read_data_out == $past(fwd_w))
		else $error("transparent collision word wrong");
	chk_fwd_pipe: assert property (coll && !rd_tr |-> ##RD_DIV s_pipe_out)
		else $error("pipelined collision word wrong");
	chk_rpar_value: assert property (rd_take && rd_tr |=>
		read_parity_error == ((^read_data_out) ^ $past(parity_odd_select)))
		else $error("read parity flag wrong");
	chk_rd_quiet: assert property (!read_clock |=> $stable(read_data_out))
		else $error("read data moved without port clock");
	chk_rd_period: assert property (read_clock |=> !read_clock [*3] ##1 read_clock)
		else $error("read port clock period wrong");
	chk_wr_strobe: assert property (!write_select_n |-> !write_strobe_n)
		else $error("write select without strobe");
	chk_rd_strobe: assert property (!read_select_n |-> !read_strobe_n)
		else $error("read select without strobe");
	chk_wr_wait: assert property ($fell(write_select_n) |-> ##[0:WR_DIV] write_clock)
		else $error("write not taken in time");
endmodule : dpr_monitor

//--- bench/tb_dual_port_ram_block.sv
/*
 * Self-checking bench joining the memory block and its user end.
 * Assumes equal port clock dividers that start in step after reset.
 */
`timescale 1ns/1ps
module tb_dual_port_ram_block;
	localparam int DIV = 4;
	logic       clk, arst_n, par_gen, par_odd, pipe, wr_req, rd_req;
	logic       wr_ready, wr_perr, rd_ready, rd_valid, rd_perr;
	logic [7:0] wr_addr, rd_addr, a, b;
	logic [8:0] wr_data, rd_data, d, mem_m [256];
	int         bad_count, tests_run, seed_v;

	dpr_if bus ();
	dpr_mem_block u_dpr_mem_block (.CLK_I(clk), .ARST_N_I(arst_n), .PORT(bus));
	dpr_user_port #(.WR_DIV(DIV), .RD_DIV(DIV)) u_dpr_user_port (
		.CLK_I(clk), .ARST_N_I(arst_n), .PAR_GEN_I(par_gen), .PAR_ODD_I(par_odd),
		.PIPELINED_I(pipe), .WR_REQ_I(wr_req), .WR_ADDR_I(wr_addr), .WR_DATA_I(wr_data),
		.WR_READY_O(wr_ready), .WR_PERR_O(wr_perr), .RD_REQ_I(rd_req), .RD_ADDR_I(rd_addr),
		.RD_READY_O(rd_ready), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data),
		.RD_PERR_O(rd_perr), .PORT(bus));
	dpr_monitor #(.WR_DIV(DIV), .RD_DIV(DIV)) u_dpr_monitor (
		.CLK_I(clk), .ARST_N_I(arst_n), .write_clock(bus.write_clock),
		.write_address(bus.write_address), .write_select_n(bus.write_select_n),
		.write_strobe_n(bus.write_strobe_n), .write_data_in(bus.write_data_in),
		.parity_generate(bus.parity_generate), .parity_odd_select(bus.parity_odd_select),
		.write_parity_error(bus.write_parity_error), .read_clock(bus.read_clock),
		.read_address(bus.read_address), .read_select_n(bus.read_select_n),
		.read_strobe_n(bus.read_strobe_n), .read_mode(bus.read_mode),
		.read_data_out(bus.read_data_out), .read_parity_error(bus.read_parity_error));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [8:0] gen_word(input logic [8:0] w);
		gen_word = w;
		if (par_gen)
			gen_word[8] = (^w[7:0]) ^ par_odd;
	endfunction : gen_word

	task automatic cmp_word(input string what, input logic [8:0] e, input logic [8:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_word

	task automatic cmp_flag(input string what, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %b seen %b", what, e, g);
		end
	endtask : cmp_flag

	// Write and/or read in one go; equal addresses collide on one port clock
	task automatic xfer(input logic dw, input logic dr, input logic [7:0] wa,
			input logic [8:0] wd, input logic [7:0] ra);
		logic [8:0] e;
		int         n;
		n = 0;
		while ((wr_ready & rd_ready) !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		e = (dw && wa == ra) ? gen_word(wd) : mem_m[ra];
		wr_req = dw;
		rd_req = dr;
		wr_addr = wa;
		wr_data = wd;
		rd_addr = ra;
		@(negedge clk);
		wr_req = 1'b0;
		rd_req = 1'b0;
		cmp_flag("wr_ready", !dw, wr_ready);
		cmp_flag("rd_ready", !dr, rd_ready);
		n = 0;
		while (dr && rd_valid !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		if (dr) begin
			cmp_flag("rd_valid", 1'b1, rd_valid);
			cmp_word("rd_data", e, rd_data);
			cmp_flag("rd_perr", (^e) ^ par_odd, rd_perr);
		end
		n = 0;
		while (dw && wr_ready !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		if (dw) begin
			cmp_flag("wr_ready", 1'b1, wr_ready);
			cmp_flag("wr_perr", !par_gen && ((^wd) ^ par_odd), wr_perr);
			mem_m[wa] = gen_word(wd);
		end
	endtask : xfer

	// Read of a word launched first, write to it one port clock later: old word returns
	task automatic late_write(input logic [7:0] wa, input logic [8:0] wd);
		logic [8:0] e;
		int         n;
		e = mem_m[wa];
		n = 0;
		while ((wr_ready & rd_ready) !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		rd_req = 1'b1;
		rd_addr = wa;
		@(negedge clk);
		rd_req = 1'b0;
		n = 0;
		while (bus.read_select_n !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		wr_req = 1'b1;
		wr_addr = wa;
		wr_data = wd;
		if (!pipe) begin
			cmp_flag("rd_valid", 1'b1, rd_valid);
			cmp_word("rd_old", e, rd_data);
		end
		@(negedge clk);
		wr_req = 1'b0;
		if (pipe) begin
			n = 0;
			while (rd_valid !== 1'b1 && n < 30) begin
				@(negedge clk);
				n++;
			end
			cmp_flag("rd_valid", 1'b1, rd_valid);
			cmp_word("rd_old", e, rd_data);
		end
		n = 0;
		while (wr_ready !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		cmp_flag("wr_ready", 1'b1, wr_ready);
		mem_m[wa] = gen_word(wd);
	endtask : late_write

	task automatic print_verdict();
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	initial begin
		#(100 * 30000);
		bad_count++;
		print_verdict();
	end

	initial begin
		bad_count = 0;
		tests_run = 0;
		{arst_n, par_gen, par_odd, pipe, wr_req, rd_req} = 6'h00;
		{wr_addr, rd_addr, wr_data} = 25'h0000000;
		foreach (mem_m[i]) mem_m[i] = 9'h000;
		seed_v = $urandom(14436);
		repeat (4) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		xfer(1'b0, 1'b1, 8'h00, 9'h000, 8'hFF);
		for (int c = 0; c < 8; c++) begin
			{pipe, par_gen, par_odd} = 3'(c);
			xfer(1'b1, 1'b1, 8'hFF, 9'h1FF, 8'hFF);
			xfer(1'b1, 1'b1, 8'h00, 9'h100, 8'h00);
			repeat (6) begin
				a = 8'($urandom);
				b = 8'($urandom);
				d = 9'($urandom);
				xfer(1'b1, 1'b0, a, d, a);
				xfer(1'($urandom), 1'b1, b, ~d, a);
			end
			late_write(b, d ^ 9'h0AA);
		end
		arst_n = 1'b0;
		@(negedge clk);
		arst_n = 1'b1;
		foreach (mem_m[i]) mem_m[i] = 9'h000;
		xfer(1'b0, 1'b1, 8'h00, 9'h000, a);
		print_verdict();
	end
endmodule : tb_dual_port_ram_block
